// file: include/strap_ratio_consts.svh
// constants for the power-up clock-ratio strap logic
`ifndef STRAP_RATIO_CONSTS_SVH
`define STRAP_RATIO_CONSTS_SVH
`define PLAT_STRAP_W      4
`define CORE_STRAP_W      3
`define PLAT_X16          4'h0
`define PLAT_X3           4'h3
`define PLAT_X4           4'h4
`define PLAT_X5           4'h5
`define PLAT_X6           4'h6
`define PLAT_X8           4'h8
`define PLAT_X9           4'h9
`define PLAT_X10          4'hA
`define PLAT_X12          4'hC
`define CORE_4_1          3'h0
`define CORE_3_2          3'h3
`define CORE_2_1          3'h4
`define CORE_5_2          3'h5
`define CORE_3_1          3'h6
`define CORE_7_2          3'h7
`define PCI_OPT_MIN_MHZ   33
`define PCI_OPT_MAX_MHZ   66
`define SYNC_RST_RATIO    5'h00
`define PLAT_CODE_RST     4'h0
`define CORE_CODE_RST     3'h0
`define MULT_RST          5'h00
`define NUM_RST           3'h0
`define DEN_RST           2'h0
`endif

// file: include/strap_ratio_pkg.sv
// types for the power-up clock-ratio strap logic
package strap_ratio_pkg;
  typedef logic [4:0] mult_t;
  typedef enum {ST_RESET, ST_LATCH, ST_RUN} cfg_state_e;
endpackage

// file: verilog/strap_sync.sv
// two-flop synchroniser for a bundle of strap pins
`default_nettype none
module strap_sync #(
  parameter int W = 1
) (
  // clock
  input  wire logic         clk,
  // pins in, synchronised out
  input  wire logic [W-1:0] pin_in,
  output var  logic [W-1:0] pin_sync
);
  logic [W-1:0] stage1_reg;

  // no reset: the flops follow the pins through reset, so the straps are settled at release
  always_ff @(posedge clk) begin
    stage1_reg <= pin_in;
    pin_sync   <= stage1_reg;
  end
endmodule
`default_nettype wire

// file: verilog/reset_strap_clock_ratio.sv
// power-up clock-ratio strap sampling and decode
// Notes on behaviour
// [R1] platform strap decodes to platform multiplier
// [R2] board must drive a valid platform code
// [R3] platform clock must equal memory data rate
// [R4] core strap decodes to core-to-platform ratio
// [R5] memory bus clock is half platform
// [R6] pci clock optional for 33-66 MHz input
// [R7] internal pull-ups only while in reset
// [R8] board keeps test select high, acknowledges valid
// [R9] board keeps platform clock at least 333 MHz
// [R10] straps latched at reset release, then held
`default_nettype none
`include "strap_ratio_consts.svh"
module reset_strap_clock_ratio
  import strap_ratio_pkg::*;
#(
  parameter int SYS_CLK_MHZ = 66
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // strap pins
  input  wire logic [3:0] platform_ratio_strap,
  input  wire logic       buffer_control_strap_pin,
  input  wire logic       address_latch_strap_pin,
  input  wire logic       general_purpose_line_two,
  // pull-up control
  output logic            strap_pullup_en,
  // decoded platform ratio: platform = input * mult
  output logic [4:0]      platform_mult,
  output logic            platform_code_valid,
  // decoded core ratio: core/platform = num/den
  output logic [2:0]      core_ratio_num,
  output logic [1:0]      core_ratio_den,
  output logic            core_code_valid,
  // memory bus ratio as half-steps of input clock: mem = input * mem_half_mult / 2
  output logic [4:0]      mem_half_mult,
  // pci clock pin needed
  output logic            pci_clk_required,
  // configuration finished, results stand
  output logic            config_done
);
  // synchronised strap codes, settled before reset is released
  logic [3:0]  plat_sync;
  logic [2:0]  core_sync;
  // raw strap codes frozen at reset release
  logic [3:0]  plat_reg;
  logic [2:0]  core_reg;
  // configuration sequence
  cfg_state_e  state_reg;
  cfg_state_e  state_next;
  // decoded fields of the frozen codes
  logic [5:0]  plat_dec;
  logic [5:0]  core_dec;
  logic [4:0]  plat_mult_w;
  logic        plat_ok_w;
  logic [2:0]  core_num_w;
  logic [1:0]  core_den_w;
  logic        core_ok_w;
  logic        pci_opt;
  logic        capture_en;
  logic        publish_en;

  // two flops per pin: the straps come from the board, outside this clock
  strap_sync #(
    .W (`PLAT_STRAP_W)
  ) u_plat_sync (
    .clk      (clk),
    .pin_in   (platform_ratio_strap),
    .pin_sync (plat_sync)
  );

  strap_sync #(
    .W (`CORE_STRAP_W)
  ) u_core_sync (
    .clk      (clk),
    .pin_in   ({buffer_control_strap_pin, address_latch_strap_pin, general_purpose_line_two}),
    .pin_sync (core_sync)
  );

  // decode tables: the top bit flags a code that is not reserved
  function automatic logic [5:0] plat_decode(input logic [3:0] code);
    case (code)
      `PLAT_X16: plat_decode = {1'b1, 5'h10}; // R1
      `PLAT_X3:  plat_decode = {1'b1, 5'h03};
      `PLAT_X4:  plat_decode = {1'b1, 5'h04};
      `PLAT_X5:  plat_decode = {1'b1, 5'h05};
      `PLAT_X6:  plat_decode = {1'b1, 5'h06};
      `PLAT_X8:  plat_decode = {1'b1, 5'h08};
      `PLAT_X9:  plat_decode = {1'b1, 5'h09};
      `PLAT_X10: plat_decode = {1'b1, 5'h0A};
      `PLAT_X12: plat_decode = {1'b1, 5'h0C};
      default:   plat_decode = {1'b0, 5'h00};
    endcase
  endfunction

  function automatic logic [5:0] core_decode(input logic [2:0] code);
    case (code)
      `CORE_4_1: core_decode = {1'b1, 3'h4, 2'h1}; // R4
      `CORE_3_2: core_decode = {1'b1, 3'h3, 2'h2};
      `CORE_2_1: core_decode = {1'b1, 3'h2, 2'h1};
      `CORE_5_2: core_decode = {1'b1, 3'h5, 2'h2};
      `CORE_3_1: core_decode = {1'b1, 3'h3, 2'h1};
      `CORE_7_2: core_decode = {1'b1, 3'h7, 2'h2};
      default:   core_decode = {1'b0, 3'h0, 2'h0};
    endcase
  endfunction

  // decode is a pure function of the frozen codes, so the fields settle once
  assign plat_dec    = plat_decode(plat_reg);
  assign core_dec    = core_decode(core_reg);
  assign plat_ok_w   = plat_dec[5];
  assign plat_mult_w = plat_dec[4:0];
  assign core_ok_w   = core_dec[5];
  assign core_num_w  = core_dec[4:2];
  assign core_den_w  = core_dec[1:0];

  // the pci clock pin may stay unused only for a 33 to 66 MHz input clock
  assign pci_opt = (SYS_CLK_MHZ >= `PCI_OPT_MIN_MHZ) && (SYS_CLK_MHZ <= `PCI_OPT_MAX_MHZ);

  // codes are taken on the first edge after release, results one edge later
  assign capture_en = (state_reg == ST_RESET);
  assign publish_en = (state_reg == ST_LATCH);

  // reset -> capture -> publish -> run; run is left only through reset
  always_comb begin
    case (state_reg)
      ST_RESET: state_next = ST_LATCH;
      ST_LATCH: state_next = ST_RUN;
      ST_RUN:   state_next = ST_RUN;
      default:  state_next = ST_RESET;
    endcase
  end

  // sequence register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg <= ST_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // frozen codes: later pin changes never reach the decode
  always_ff @(posedge clk) begin
    if (!rstn) begin
      plat_reg <= `PLAT_CODE_RST;
    end else if (capture_en) begin
      plat_reg <= plat_sync; // R10
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      core_reg <= `CORE_CODE_RST;
    end else if (capture_en) begin
      core_reg <= core_sync; // R10
    end
  end

  // published results stand from the publish edge until the next reset
  always_ff @(posedge clk) begin
    if (!rstn) begin
      platform_mult <= `MULT_RST;
    end else if (publish_en) begin
      platform_mult <= plat_mult_w; // R1
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      platform_code_valid <= 1'h0;
    end else if (publish_en) begin
      platform_code_valid <= plat_ok_w; // R1
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      core_ratio_num <= `NUM_RST;
    end else if (publish_en) begin
      core_ratio_num <= core_num_w; // R4
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      core_ratio_den <= `DEN_RST;
    end else if (publish_en) begin
      core_ratio_den <= core_den_w; // R4
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      core_code_valid <= 1'h0;
    end else if (publish_en) begin
      core_code_valid <= core_ok_w; // R4
    end
  end

  // memory clock in half-steps of the input: half the platform clock
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mem_half_mult <= `SYNC_RST_RATIO;
    end else if (publish_en) begin
      mem_half_mult <= plat_mult_w; // R5
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      config_done <= 1'h0;
    end else if (publish_en) begin
      config_done <= 1'h1; // R10
    end
  end

  // pull-ups help undriven straps only while the device is held in reset
  assign strap_pullup_en  = !rstn; // R7
  // a build-time fact of the input clock, not a sampled strap
  assign pci_clk_required = !pci_opt; // R6
endmodule
`default_nettype wire

// file: verification/strap_ratio_chk_assertions.sv
// assertions for the strap ratio decode
`default_nettype none
module strap_ratio_chk (
  input wire logic clk, rstn, strap_pullup_en, config_done, platform_code_valid, core_code_valid,
  input wire logic [4:0] platform_mult, mem_half_mult,
  input wire logic [2:0] core_ratio_num,
  input wire logic [1:0] core_ratio_den
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_pullup_off: assert property (!strap_pullup_en) else $error("pullup on");
  a_mem_half: assert property (config_done |-> mem_half_mult == platform_mult) else $error("mem");
  a_plat_flag: assert property (config_done |-> platform_code_valid == (platform_mult != 5'h00)) else $error("plat");
  a_core_pair: assert property (config_done |-> (core_ratio_den == 2'h0) == (core_ratio_num == 3'h0)) else $error("core");
  a_ratio_hold: assert property (config_done |=> config_done && $stable({platform_mult, core_ratio_num})) else $error("hold");
  a_core_flag: assert property (config_done |-> core_code_valid == (core_ratio_den != 2'h0)) else $error("core flag");
endmodule
bind reset_strap_clock_ratio strap_ratio_chk i_strap_ratio_chk (.clk, .rstn, .strap_pullup_en, .config_done,
  .platform_code_valid, .core_code_valid, .platform_mult, .mem_half_mult, .core_ratio_num, .core_ratio_den);
`default_nettype wire

// file: verification/strap_board_model.sv
// board strap drivers, always actively driven
`default_nettype none
module strap_board_model (
  input  wire logic [6:0] sel,
  output logic      [6:0] straps
);
  timeunit 1ns;
  timeprecision 1ns;
  assign straps = sel;
endmodule
`default_nettype wire

// file: verification/reset_strap_clock_ratio_tb_top.sv
// bench for the strap ratio decode
`default_nettype none
module reset_strap_clock_ratio_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rstn, pu, done, pv, pci;
  logic [6:0] sel, st;
  logic       cv;
  logic [4:0] mult, mhm, nd;
  logic [2:0] num;
  logic [1:0] den;
  assign nd = {num, den};
  int errors, tests_run, cyc;
  strap_board_model i_strap_board_model (.sel, .straps(st));
  reset_strap_clock_ratio i_reset_strap_clock_ratio (.clk, .rstn, .platform_ratio_strap(st[6:3]),
    .buffer_control_strap_pin(st[2]), .address_latch_strap_pin(st[1]), .general_purpose_line_two(st[0]),
    .strap_pullup_en(pu), .platform_mult(mult), .platform_code_valid(pv), .core_ratio_num(num),
    .core_ratio_den(den), .core_code_valid(cv), .mem_half_mult(mhm), .pci_clk_required(pci), .config_done(done));
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [7:0] g, e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %0t %h %h", $time, g, e);
    end
  endtask
  task automatic cfg(input logic [6:0] s);
    rstn = 0;
    sel = s;
    repeat (12) @(negedge clk);
    chk(8'(pu), 8'h01);
    rstn = 1;
    repeat (6) @(negedge clk);
    chk({5'h00, done, pu, pci}, 8'h04);
  endtask
  task automatic plat_codes;
    for (int i = 0; i < 16; i++) begin
      logic [7:0] exp_mult;
      exp_mult = (i == 0) ? 8'h10 : (i inside {3, 4, 5, 6, 8, 9, 10, 12}) ? 8'(i) : 8'h00;
      cfg({4'(i), 3'h0});
      chk(8'(mult), exp_mult);
      chk(8'(mhm), exp_mult);
      chk(8'(pv), 8'(i inside {0, 3, 4, 5, 6, 8, 9, 10, 12}));
    end
  endtask
  task automatic core_codes;
    logic [4:0] r [8] = '{5'h11, 5'h00, 5'h00, 5'h0E, 5'h09, 5'h16, 5'h0D, 5'h1E};
    for (int i = 0; i < 8; i++) begin
      cfg({4'h4, 3'(i)});
      chk(8'(nd), 8'(r[i]));
      chk(8'(cv), 8'(r[i] != 5'h00));
      chk(8'(mhm), 8'h04);
    end
  endtask
  task automatic hold_after_release;
    cfg(7'h67);
    sel = 7'h18;
    repeat (8) @(negedge clk);
    chk({mult, nd[4:2]}, {5'h0C, 3'h7});
    chk(8'(den), 8'h02);
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      complete_run;
    end
  end
  initial begin
    rstn = 0;
    sel = 0;
    @(negedge clk);
    plat_codes;
    core_codes;
    hold_after_release;
    complete_run;
  end
endmodule
`default_nettype wire
